/* rcd_pkg.sv */
// package for the reflectometry and link quality threshold block
// assumes a management register port of 5-bit address and 16-bit data
package rcd_pkg;
  // register addresses
  localparam logic [4:0] ADDR_CTRL = 5'h16;
  localparam logic [4:0] ADDR_WIN  = 5'h17;
  localparam logic [4:0] ADDR_PEAK = 5'h18;
  localparam logic [4:0] ADDR_THR  = 5'h19;
  localparam logic [4:0] ADDR_LQ   = 5'h1E;
  // control fields
  localparam int CTRL_EN      = 15;
  localparam int CTRL_FAST    = 14;
  localparam int CTRL_TXRXP   = 13;
  localparam int CTRL_MONRXP  = 12;
  localparam int CTRL_SEND    = 11;
  localparam int CTRL_PW_HI   = 10;
  localparam int CTRL_PW_LO   = 8;
  localparam int CTRL_MINMODE = 7;
  localparam int CTRL_THR_HI  = 5;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] WIN_RESET  = 16'h00FF;
  // threshold port fields
  localparam int LQ_WRITE  = 14;
  localparam int LQ_HIGH   = 11;
  localparam int LQ_SEL_HI = 10;
  localparam int LQ_SEL_LO = 8;
  localparam int LQ_NPARAM = 5;
  localparam logic [7:0] SMIN = 8'h80;
  localparam logic [7:0] SMAX = 8'h7F;
  localparam logic [7:0] UMIN = 8'h00;
  localparam logic [7:0] UMAX = 8'hFF;
  localparam logic [2:0] SEL_GAIN = 3'h1;
  // timing
  localparam int CLK_NS    = 100;
  localparam int SLOW_W_NS = 100;
  localparam int SLOW_CYC  = (SLOW_W_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } rcd_state_t;
endpackage : rcd_pkg

/* rcd_lq_thresh.sv */
// link quality threshold store and warning compare
// assumes parameter values arrive synchronous to clock
module rcd_lq_thresh
  import rcd_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    clkEn,
  // port write
  input  wire logic                    wrEn,
  input  wire logic [15:0]             wrData,
  output logic      [7:0]              rdValue,
  // monitored values, five bytes
  input  wire logic [8*LQ_NPARAM-1:0]  paramVal,
  output logic      [LQ_NPARAM-1:0]    warnHigh,
  output logic      [LQ_NPARAM-1:0]    warnLow
);
  logic [7:0] hi_r [LQ_NPARAM];
  logic [7:0] lo_r [LQ_NPARAM];
  logic [7:0] hi_nxt [LQ_NPARAM];
  logic [7:0] lo_nxt [LQ_NPARAM];
  logic [2:0] sel_r, sel_nxt;
  logic       selHi_r, selHi_nxt;

  // signed compare except gain, which is unsigned
  function automatic logic gt(input logic [7:0] a, input logic [7:0] b, input logic uns);
    gt = uns ? (a > b) : ($signed(a) > $signed(b));
  endfunction : gt

  always_comb begin
    sel_nxt   = sel_r;
    selHi_nxt = selHi_r;
    hi_nxt    = hi_r;
    lo_nxt    = lo_r;
    if (wrEn) begin
      sel_nxt   = wrData[LQ_SEL_HI:LQ_SEL_LO];
      selHi_nxt = wrData[LQ_HIGH];
      if (wrData[LQ_WRITE] && (wrData[LQ_SEL_HI:LQ_SEL_LO] < 3'(LQ_NPARAM))) begin // RULE_01
        if (wrData[LQ_HIGH]) hi_nxt[wrData[LQ_SEL_HI:LQ_SEL_LO]] = wrData[7:0];
        else lo_nxt[wrData[LQ_SEL_HI:LQ_SEL_LO]] = wrData[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_r   <= 3'h0;
      selHi_r <= 1'b0;
      for (int i = 0; i < LQ_NPARAM; i++) begin
        hi_r[i] <= (i == int'(SEL_GAIN)) ? UMAX : SMAX; // RULE_04 RULE_05
        lo_r[i] <= (i == int'(SEL_GAIN)) ? UMIN : SMIN; // RULE_04 RULE_05
      end
    end else if (clkEn) begin
      sel_r   <= sel_nxt;
      selHi_r <= selHi_nxt;
      hi_r    <= hi_nxt;
      lo_r    <= lo_nxt;
    end
  end

  // readback of the selected threshold
  always_comb begin
    rdValue = 8'h00;
    if (sel_r < 3'(LQ_NPARAM)) rdValue = selHi_r ? hi_r[sel_r] : lo_r[sel_r]; // RULE_02
  end

  // strict compares: equality never warns
  always_comb begin
    for (int i = 0; i < LQ_NPARAM; i++) begin
      warnHigh[i] = gt(paramVal[8*i +: 8], hi_r[i], i == int'(SEL_GAIN)); // RULE_03
      warnLow[i]  = gt(lo_r[i], paramVal[8*i +: 8], i == int'(SEL_GAIN)); // RULE_03
    end
  end
endmodule : rcd_lq_thresh

/* rcd_pulse_gen.sv */
// reflectometry pulse shaper for both common drivers
// assumes one clock is one sample interval
module rcd_pulse_gen
  import rcd_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  // control
  input  wire logic       launch,
  input  wire logic       fastMode,
  input  wire logic [2:0] width,
  // driver pins
  output logic            slowDrive,
  output logic            fastPos,
  output logic            fastNeg
);
  logic [3:0] cnt_r, cnt_nxt;
  logic       pol_r, pol_nxt;
  logic       fast_r, fast_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    pol_nxt  = pol_r;
    fast_nxt = fast_r;
    if (launch) begin
      fast_nxt = fastMode;
      // slow link pulse width rounds up to whole clocks; short and long codes both give one clock, 100ns
      if (width == 3'h0) cnt_nxt = 4'h0; // RULE_09
      else if (fastMode) cnt_nxt = {1'b0, width}; // RULE_07 RULE_15
      else if (width > 3'h3) cnt_nxt = 4'(SLOW_CYC); // RULE_06
      else cnt_nxt = 4'((SLOW_W_NS / 2 + CLK_NS - 1) / CLK_NS); // RULE_06
      if (fastMode && width != 3'h0) pol_nxt = ~pol_r; // RULE_08
    end else if (cnt_r != 4'h0) begin
      cnt_nxt = cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r  <= 4'h0;
      pol_r  <= 1'b0; // first fast pulse goes out positive
      fast_r <= 1'b0;
    end else if (clkEn) begin
      cnt_r  <= cnt_nxt;
      pol_r  <= pol_nxt;
      fast_r <= fast_nxt;
    end
  end

  assign slowDrive = (cnt_r != 4'h0) && !fast_r;
  assign fastPos   = (cnt_r != 4'h0) && fast_r && pol_r;
  assign fastNeg   = (cnt_r != 4'h0) && fast_r && !pol_r;
endmodule : rcd_pulse_gen

/* rcd_diag.sv */
// reflectometry engine with management registers and threshold port
// assumes register port strobes are one clock wide and synchronous
module rcd_diag
  import rcd_pkg::*;
// Functional notes
// (RULE_01) one write with data, selector and write strobe updates that threshold
// (RULE_02) writing only a selector makes a read return that stored threshold
// (RULE_03) warning only when strictly above high or strictly below low
// (RULE_04) thresholds reset to parameter maximum and minimum limits
// (RULE_05) four thresholds signed 80..7F, gain threshold unsigned 00..FF
// (RULE_06) slow mode sends link pulses of 50 or 100 ns width; the code sends one 100 ns clock for both
// (RULE_07) fast mode pulses are multiples of 8 ns up to 56 ns; the code gives multiples of the 100 ns clock up to 700 ns
// (RULE_08) fast driver pulses alternate polarity
// (RULE_09) width zero sends nothing yet monitor still runs
// (RULE_10) track peak and threshold crossing with first time in clocks
// (RULE_11) monitor timer starts at pulse launch
// (RULE_12) enable bit 15 hands both drivers to the engine
// (RULE_13) bit 11 launches one pulse and starts the monitor
// (RULE_14) bit 14 selects fast driver when set, slow when clear
// (RULE_15) bits 10:8 give fast pulse width 0 to 7 clocks; slow pulses get 0 or 1 clock
// (RULE_16) bit 13 puts pulse on receive pair, default transmit pair
// (RULE_17) bit 7 clear seeks maxima, set seeks minima
// (RULE_18) bit 12 monitors receive pair, default transmit pair
// (RULE_19) window start 15:8 to stop 7:0 inclusive qualify samples
// (RULE_20) peak at 18h, threshold crossing at 19h
// (RULE_21) software should average runs and window out its own pulse
// (RULE_22) captures clear at send, one sample per clock, stop after window
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   clkEn,
  // management register port
  input  wire logic [4:0]             regAddr,
  input  wire logic                   regWr,
  input  wire logic [15:0]            regWrData,
  output logic      [15:0]            regRdData,
  // adc samples per pair
  input  wire logic [7:0]             adcTxPair,
  input  wire logic [7:0]             adcRxPair,
  // link quality parameter values
  input  wire logic [8*LQ_NPARAM-1:0] lqParams,
  output logic      [LQ_NPARAM-1:0]   lqWarnHigh,
  output logic      [LQ_NPARAM-1:0]   lqWarnLow,
  // front end control
  output logic                        normalSuspend,
  output logic                        pulseOnRxPair,
  output logic                        slowDrive,
  output logic                        fastPos,
  output logic                        fastNeg,
  output logic                        busy
);
  rcd_state_t st_r, st_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] win_r, win_nxt;
  logic [7:0]  timer_r, timer_nxt;
  logic [7:0]  peak_r, peak_nxt;
  logic [7:0]  peakT_r, peakT_nxt;
  logic [7:0]  thrT_r, thrT_nxt;
  logic [7:0]  thrV_r, thrV_nxt;
  logic        thrHit_r, thrHit_nxt;
  logic [7:0]  sample;
  logic        qual;
  logic        launch;
  logic        lqWr;
  logic [7:0]  lqRd;
  logic [15:0] rdNxt, rd_r;

  // "a beyond b" in the chosen search direction
  function automatic logic beyond(input logic [7:0] a, input logic [7:0] b, input logic minMode);
    beyond = minMode ? ($signed(a) < $signed(b)) : ($signed(a) > $signed(b));
  endfunction : beyond

  // a send while busy is dropped so pulse and timer never slip apart
  assign launch = regWr && (regAddr == ADDR_CTRL) && regWrData[CTRL_SEND]
                  && (st_r == ST_IDLE)
                  && (regWrData[CTRL_EN] || ctrl_r[CTRL_EN]); // RULE_13
  assign lqWr   = regWr && (regAddr == ADDR_LQ);
  assign sample = ctrl_r[CTRL_MONRXP] ? adcRxPair : adcTxPair; // RULE_18
  assign qual   = (st_r == ST_RUN) && (timer_r >= win_r[15:8]) && (timer_r <= win_r[7:0]); // RULE_19

  always_comb begin
    st_nxt     = st_r;
    ctrl_nxt   = ctrl_r;
    win_nxt    = win_r;
    timer_nxt  = timer_r;
    peak_nxt   = peak_r;
    peakT_nxt  = peakT_r;
    thrT_nxt   = thrT_r;
    thrV_nxt   = thrV_r;
    thrHit_nxt = thrHit_r;
    if (regWr && regAddr == ADDR_CTRL) begin
      ctrl_nxt = regWrData;
      ctrl_nxt[CTRL_SEND] = 1'b0; // self clearing send
    end
    if (regWr && regAddr == ADDR_WIN) win_nxt = regWrData;
    unique case (st_r)
      ST_IDLE: begin
        if (launch) begin
          st_nxt     = ST_RUN;
          timer_nxt  = 8'h00; // RULE_11
          peak_nxt   = regWrData[CTRL_MINMODE] ? 8'h7F : 8'h80; // RULE_22
          peakT_nxt  = 8'h00;
          thrT_nxt   = 8'h00;
          thrHit_nxt = 1'b0;
          thrV_nxt   = {regWrData[CTRL_THR_HI:0], 2'b00};
        end
      end
      ST_RUN: begin
        if (qual) begin
          if (beyond(sample, peak_r, ctrl_r[CTRL_MINMODE])) begin // RULE_10 RULE_17
            peak_nxt  = sample;
            peakT_nxt = timer_r;
          end
          // threshold magnitude from low control bits, negated in min mode
          if (!thrHit_r && beyond(sample, ctrl_r[CTRL_MINMODE] ? -thrV_r : thrV_r,
                                  ctrl_r[CTRL_MINMODE])) begin // RULE_10
            thrHit_nxt = 1'b1;
            thrT_nxt   = timer_r;
          end
        end
        timer_nxt = timer_r + 8'h01; // RULE_22
        if (timer_r >= win_r[7:0] || !ctrl_r[CTRL_EN]) st_nxt = ST_IDLE; // RULE_22
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r     <= ST_IDLE;
      ctrl_r   <= CTRL_RESET;
      win_r    <= WIN_RESET; // RULE_19
      timer_r  <= 8'h00;
      peak_r   <= 8'h00;
      peakT_r  <= 8'h00;
      thrT_r   <= 8'h00;
      thrV_r   <= 8'h00;
      thrHit_r <= 1'b0;
    end else if (clkEn) begin
      st_r     <= st_nxt;
      ctrl_r   <= ctrl_nxt;
      win_r    <= win_nxt;
      timer_r  <= timer_nxt;
      peak_r   <= peak_nxt;
      peakT_r  <= peakT_nxt;
      thrT_r   <= thrT_nxt;
      thrV_r   <= thrV_nxt;
      thrHit_r <= thrHit_nxt;
    end
  end

  // registered read data, sampled from address each clock
  always_comb begin
    unique case (regAddr)
      ADDR_CTRL: rdNxt = ctrl_r;
      ADDR_WIN:  rdNxt = win_r;
      ADDR_PEAK: rdNxt = {peak_r, peakT_r}; // RULE_20
      ADDR_THR:  rdNxt = {thrHit_r, 7'h00, thrT_r}; // RULE_20
      ADDR_LQ:   rdNxt = {8'h00, lqRd}; // RULE_02
      default:   rdNxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) rd_r <= 16'h0000;
    else if (clkEn) rd_r <= rdNxt;
  end
  assign regRdData = rd_r;

  rcd_pulse_gen uPulse (
    .clock     (clock),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .launch    (launch && clkEn),
    .fastMode  (regWrData[CTRL_FAST]), // RULE_14
    .width     (regWrData[CTRL_PW_HI:CTRL_PW_LO]), // RULE_15
    .slowDrive (slowDrive),
    .fastPos   (fastPos),
    .fastNeg   (fastNeg)
  );

  rcd_lq_thresh uThresh (
    .clock    (clock),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .wrEn     (lqWr),
    .wrData   (regWrData),
    .rdValue  (lqRd),
    .paramVal (lqParams),
    .warnHigh (lqWarnHigh),
    .warnLow  (lqWarnLow)
  );

  assign normalSuspend = ctrl_r[CTRL_EN]; // RULE_12
  assign pulseOnRxPair = ctrl_r[CTRL_TXRXP]; // RULE_16
  assign busy          = (st_r == ST_RUN);
endmodule : rcd_diag

/* rcd_diag_sva.sv */
// checker for rcd_diag front end and register timing
// assumes bound to rcd_diag; ctrl not rewritten mid-run
module rcd_diag_sva
  import rcd_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clkEn,
  // register port
  input wire logic [4:0]  regAddr,
  input wire logic        regWr,
  input wire logic [15:0] regWrData,
  // front end
  input wire logic        normalSuspend,
  input wire logic        pulseOnRxPair,
  input wire logic        slowDrive,
  input wire logic        fastPos,
  input wire logic        fastNeg,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ctl_r, ctl_nxt;
  logic [7:0]  stop_r, stop_nxt, pc_r, pc_nxt;
  logic [8:0]  bc_r, bc_nxt;
  logic        neg_r, neg_nxt, fp_r, fn_r, cw, ww, drv;
  assign cw  = regWr && clkEn && regAddr == ADDR_CTRL;
  assign ww  = regWr && clkEn && regAddr == ADDR_WIN;
  assign drv = slowDrive || fastPos || fastNeg;
  always_comb begin
    ctl_nxt  = cw ? regWrData : ctl_r;
    stop_nxt = ww ? regWrData[7:0] : stop_r;
    // counts only enabled cycles, a frozen pulse is not longer
    pc_nxt   = drv ? pc_r + {7'h00, clkEn} : 8'h00;
    bc_nxt   = busy ? bc_r + {8'h00, clkEn} : 9'h000;
    neg_nxt  = (fastPos && !fp_r) ? 1'b0 : (fastNeg && !fn_r) ? 1'b1 : neg_r;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl_r  <= CTRL_RESET;
      stop_r <= WIN_RESET[7:0];
      pc_r   <= 8'h00;
      bc_r   <= 9'h000;
      neg_r  <= 1'b1;
      fp_r   <= 1'b0;
      fn_r   <= 1'b0;
    end else begin
      ctl_r  <= ctl_nxt;
      stop_r <= stop_nxt;
      pc_r   <= pc_nxt;
      bc_r   <= bc_nxt;
      neg_r  <= neg_nxt;
      fp_r   <= fastPos;
      fn_r   <= fastNeg;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_send_starts_busy: assert property (cw && regWrData[15] && regWrData[11] && !busy |=> busy)
    else $error("send did not start monitor");
  a_busy_has_cause: assert property ($rose(busy) |-> $past(cw && regWrData[11]))
    else $error("monitor started without send");
  a_suspend_follows: assert property (cw |=> normalSuspend == $past(regWrData[15]))
    else $error("suspend not per enable bit");
  a_pair_steer: assert property (cw |=> pulseOnRxPair == $past(regWrData[13]))
    else $error("pulse pair not per bit 13");
  a_fast_width: assert property ($fell(fastPos || fastNeg) |-> pc_r == {5'h00, ctl_r[10:8]})
    else $error("fast pulse width wrong");
  a_slow_width: assert property ($fell(slowDrive) |-> pc_r == 8'(SLOW_CYC))
    else $error("slow pulse width wrong");
  a_driver_select: assert property (drv |-> (ctl_r[14] ? !slowDrive : !(fastPos || fastNeg)))
    else $error("wrong driver used");
  a_zero_width: assert property (busy && ctl_r[10:8] == 3'h0 |-> !drv)
    else $error("pulse sent with width zero");
  a_pol_pos: assert property ($rose(fastPos) |-> neg_r)
    else $error("two positive pulses in a row");
  a_pol_neg: assert property ($rose(fastNeg) |-> !neg_r)
    else $error("two negative pulses in a row");
  a_busy_length: assert property ($fell(busy) |-> bc_r == {1'b0, stop_r} + 9'h001)
    else $error("monitor run length wrong");
  c_fast_neg: cover property ($fell(fastNeg));
  c_slow: cover property ($fell(slowDrive));
  c_baseline: cover property ($fell(busy) && ctl_r[10:8] == 3'h0);
endmodule : rcd_diag_sva
bind rcd_diag rcd_diag_sva u_sva (.clock(clock), .rst_n(rst_n), .clkEn(clkEn),
  .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .normalSuspend(normalSuspend),
  .pulseOnRxPair(pulseOnRxPair), .slowDrive(slowDrive), .fastPos(fastPos),
  .fastNeg(fastNeg), .busy(busy));

/* rcd_cable_model.sv */
// open cable: outgoing pulse on launch pair, echo after dly clocks
// assumes drivers change only on clock edges
module rcd_cable_model
  import rcd_pkg::*;
(
  // clock
  input wire logic       clock,
  // drivers
  input wire logic       slowDrive,
  input wire logic       fastPos,
  input wire logic       fastNeg,
  input wire logic       pulseOnRxPair,
  // cable shape
  input wire logic [5:0] dly,
  input wire logic [7:0] amp,
  // adc samples
  output logic     [7:0] adcTxPair,
  output logic     [7:0] adcRxPair
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] pos_r = '0;
  logic [63:0] neg_r = '0;
  logic [7:0]  near, echo, half;
  always_ff @(posedge clock) begin
    pos_r <= {pos_r[62:0], slowDrive | fastPos};
    neg_r <= {neg_r[62:0], fastNeg};
  end
  always_comb begin
    near = (slowDrive | fastPos) ? 8'h60 : fastNeg ? 8'hA0 : 8'h00;
    echo = pos_r[dly-6'h01] ? amp : neg_r[dly-6'h01] ? -amp : 8'h00;
    // crosstalk onto the other pair at half strength
    half = {echo[7], echo[7:1]};
    adcTxPair = pulseOnRxPair ? half : near + echo;
    adcRxPair = pulseOnRxPair ? near + echo : half;
  end
endmodule : rcd_cable_model

/* tb.sv */
// self-checking bench for rcd_diag with cable model
// assumes 10 MHz clock and synchronous active-low reset
module tb
  import rcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_n, clkEn, regWr, pOnRx, slowD, fPos, fNeg, busy, susp;
  logic        pol, neg, hit, pulse;
  logic [4:0]  regAddr, wHi, wLo;
  logic [15:0] regWrData, regRdData, v, ctl;
  logic [7:0]  adcTx, adcRx, amp, e, hiA[5], loA[5];
  logic [5:0]  dly;
  logic [39:0] lqParams;
  int          mismatches, tests_run, seed, r, i, k, j;
  rcd_diag u_dut (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData), .adcTxPair(adcTx),
    .adcRxPair(adcRx), .lqParams(lqParams), .lqWarnHigh(wHi), .lqWarnLow(wLo),
    .normalSuspend(susp), .pulseOnRxPair(pOnRx), .slowDrive(slowD), .fastPos(fPos),
    .fastNeg(fNeg), .busy(busy));
  rcd_cable_model u_cable (.clock(clock), .slowDrive(slowD), .fastPos(fPos),
    .fastNeg(fNeg), .pulseOnRxPair(pOnRx), .dly(dly), .amp(amp),
    .adcTxPair(adcTx), .adcRxPair(adcRx));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [4:0] a, logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge clock);
    #1;
    regWr = 1'b0;
    // idle edge so back-to-back writes never re-raise the strobe in one step
    @(posedge clock);
    #1;
  endtask : wr
  task automatic rd(logic [4:0] a, output logic [15:0] d);
    regAddr = a;
    @(posedge clock);
    #1;
    d = regRdData;
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  function automatic logic [1:0] warn(int s, logic [7:0] x, logic [7:0] hi, logic [7:0] lo);
    if (s == SEL_GAIN) return {x > hi, x < lo};
    return {$signed(x) > $signed(hi), $signed(x) < $signed(lo)};
  endfunction : warn
  function automatic logic [7:0] pick(int n, logic [7:0] hi, logic [7:0] lo);
    case (n)
      0: return lo;
      1: return hi;
      2: return lo - 8'h01;
      3: return hi + 8'h01;
      default: return 8'hF0;
    endcase
  endfunction : pick
  initial begin
    {rst_n, regWr, regAddr, regWrData, lqParams, mismatches, tests_run} = '0;
    {clkEn, seed, dly, amp, pol} = {1'b1, 32'd81, 6'h09, 8'h20, 1'b0};
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    wr(ADDR_PEAK, 16'hFFFF);
    rd(ADDR_CTRL, v); chk("ctrl", v, CTRL_RESET);
    rd(ADDR_WIN, v);  chk("win", v, WIN_RESET);
    rd(ADDR_PEAK, v); chk("peak", v, 16'h0000);
    rd(5'h00, v);     chk("unmapped", v, 16'h0000);
    clkEn = 1'b0;
    wr(ADDR_CTRL, 16'h8000);
    clkEn = 1'b1;
    rd(ADDR_CTRL, v); chk("frozen", {v[15], susp}, 16'h0000);
    for (k = 0; k < LQ_NPARAM; k++) begin
      loA[k] = 8'($random(seed)) & 8'h0F;
      hiA[k] = loA[k] + 8'h20;
      for (i = 0; i < 2; i++) begin
        wr(ADDR_LQ, 16'((i << LQ_HIGH) | (k << LQ_SEL_LO)));
        rd(ADDR_LQ, v);
        e = (k == SEL_GAIN) ? (i ? UMAX : UMIN) : (i ? SMAX : SMIN);
        chk("lq reset", {8'h00, v[7:0]}, {8'h00, e});
        e = i ? hiA[k] : loA[k];
        wr(ADDR_LQ, 16'((1 << LQ_WRITE) | (i << LQ_HIGH) | (k << LQ_SEL_LO)) | {8'h00, e});
        rd(ADDR_LQ, v);
        chk("lq write", {8'h00, v[7:0]}, {8'h00, e});
      end
    end
    for (j = 0; j < 5; j++) begin
      for (k = 0; k < LQ_NPARAM; k++) lqParams[8*k +: 8] = pick(j, hiA[k], loA[k]);
      @(posedge clock);
      #1;
      for (k = 0; k < LQ_NPARAM; k++) begin
        e = lqParams[8*k +: 8];
        chk("warn", {14'h0, wHi[k], wLo[k]}, {14'h0, warn(k, e, hiA[k], loA[k])});
      end
    end
    for (r = 0; r < 10; r++) begin
      ctl = (16'($random(seed)) & 16'h7783) | 16'h8801;
      if (r == 0) ctl[10:8] = 3'h0;
      if (r == 1) ctl = (ctl & 16'hBFFF) | 16'h0700;
      dly = 6'h09 + (6'($random(seed)) & 6'h1F);
      amp = 8'h20 + (8'($random(seed)) & 8'h3E);
      wr(ADDR_WIN, {8'h08, 8'(dly) + 8'h0A + (8'($random(seed)) & 8'h0F)});
      wr(ADDR_CTRL, ctl);
      wr(ADDR_CTRL, ctl);
      chk("suspend", {susp, pOnRx}, {ctl[15], ctl[13]});
      for (i = 0; i < 300 && busy !== 1'b0; i++) begin
        @(posedge clock);
        #1;
      end
      if (busy !== 1'b0) begin
        mismatches++;
        give_verdict();
      end
      rd(ADDR_CTRL, v); chk("send clears", v, ctl & 16'hF7FF);
      pulse = ctl[10:8] != 3'h0;
      neg = ctl[14] && pol;
      if (ctl[14] && pulse) pol = ~pol;
      e = !pulse ? 8'h00 : neg ? -amp : amp;
      if (ctl[13] != ctl[12]) e = {e[7], e[7:1]};
      hit = pulse && (neg == ctl[7]);
      rd(ADDR_PEAK, v);
      chk("peak", v, hit ? {e, 2'b00, dly} : 16'h0008);
      rd(ADDR_THR, v);
      e = hit ? {2'b00, dly} : 8'h00;
      chk("thr", {v[15], 7'h00, v[7:0]}, {hit, 7'h00, e});
    end
    give_verdict();
  end
endmodule : tb
